// [logic/sdf_diag_frame.sv]
// Slave diagnostics frame: station status, interrupt blocks, error lamp.
// Assumes all inputs come from logic on CLK_SYS; the master link logic
// feeds requests and takes frame bytes with a valid/ready handshake.
//
// Behaviour
// - In interrupt mode, diagnostics alarms are reported as interrupt blocks.
// - One interrupt block at most sits in the frame after an alarm.
// - Master acknowledges a block; no new block before that acknowledgment.
// - Error lamp flashes after a diagnostics alarm.
// - Frame length follows settings, never below 6 nor above 244 bytes.
// - Excess hardware interrupts are dropped and reported as lost.
// - Station status byte one with eight flags sits at frame byte 0.
// - Bit 1 set while starting up and not ready.
// - Bit 2 set when received configuration mismatches actual one.
// - Bit 3 follows pending external diagnostics, set again on alarm.
// - Bit 4 set when an unsupported function is requested.
// - Bit 6 set when station type mismatches the expected type.
// - Bit 7 set when parameters came from another master.
// - Status byte three bit 7 flags alarm overflow, bits 0-6 zero.
// - Byte 3 holds the address of the parameter-assigning master.
`timescale 1ns/1ps
module sdf_diag_frame #(
  parameter longint BLINK_HALF = sdf_pkg::BLINK_HALF_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [sdf_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sdf_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [sdf_pkg::DATA_W-1:0] RDATA,
  input wire logic DIAG_ALARM,
  input wire logic [7:0] DIAG_CODE,
  input wire logic EXT_DIAG_ACTIVE,
  input wire logic HW_IRQ,
  input wire logic [7:0] HW_CODE,
  input wire logic BLK_ACK,
  input wire logic CFG_CHECK,
  input wire logic CFG_MATCH,
  input wire logic TYPE_MATCH,
  input wire logic UNSUP_REQ,
  input wire logic PRM_STROBE,
  input wire logic [7:0] PRM_MASTER,
  input wire logic [7:0] CUR_MASTER,
  input wire logic FRM_REQ,
  input wire logic FRM_READY,
  output logic FRM_VALID,
  output logic [7:0] FRM_DATA,
  output logic FRM_LAST,
  output logic ERR_LED
);
  import sdf_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic irq_mode_reg;
  logic ready_reg;
  logic cfg_err_reg;
  logic type_err_reg;
  logic unsup_reg;
  logic ext_diag_reg;
  logic ovfl_reg;
  logic hw_lost_reg;
  logic prm_valid_reg;
  logic [7:0] prm_master_reg;
  logic [7:0] ext_len_reg;
  logic [15:0] ident_reg;
  logic [7:0] ext_mem [0:EXT_MAX-1];
  logic blk_valid_reg;
  logic [7:0] blk_kind_reg;
  logic [7:0] blk_code_reg;
  logic [7:0] blk_seq_reg;
  logic diag_wait_reg;
  logic [7:0] diag_wait_code_reg;
  logic hw_wait_reg;
  logic [7:0] hw_wait_code_reg;
  logic led_active_reg;
  logic led_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_tick;
  sdf_state_t state_reg;
  logic [7:0] idx_reg;
  logic [7:0] len_reg;
  logic [7:0] data_reg;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [7:0] stat3;
  logic [7:0] frame_len;
  logic [7:0] byte_sel;
  logic [7:0] next_idx;
  logic wr_ctrl;
  logic wr_clear;
  logic issue_blk;
  logic accept;

  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  assign wr_clear = WR && (ADDR == OFS_CLEAR);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // Control register and frame settings
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_mode_reg <= 1'b0;
      ready_reg <= 1'b0;
      ext_len_reg <= 8'h00;
      ident_reg <= 16'h0000;
    end else if (WR) begin
      if (wr_ctrl) begin
        irq_mode_reg <= WDATA[CTRL_IRQ_MODE];
        ready_reg <= WDATA[CTRL_READY];
      end
      if (ADDR == OFS_EXTLEN) begin
        // Clamp so the frame never passes its maximum
        ext_len_reg <= (WDATA[7:0] > 8'(EXT_MAX)) ? 8'(EXT_MAX) : WDATA[7:0];
      end
      if (ADDR == OFS_IDENT) begin
        ident_reg <= WDATA[15:0];
      end
    end
  end

  // Extended diagnostics bytes, written as index and data
  always_ff @(posedge CLK_SYS) begin
    if (WR && (ADDR == OFS_EXTDATA) && (WDATA[15:8] < 8'(EXT_MAX))) begin
      ext_mem[WDATA[15:8]] <= WDATA[7:0];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      unique case (ADDR)
        OFS_CTRL: RDATA <= {30'h0000_0000, ready_reg, irq_mode_reg};
        OFS_STATUS: RDATA <= {3'h0, led_active_reg, hw_lost_reg, diag_wait_reg,
                              blk_valid_reg, hw_wait_reg, frame_len, stat3, stat1};
        OFS_EXTLEN: RDATA <= {24'h00_0000, ext_len_reg};
        OFS_IDENT: RDATA <= {16'h0000, ident_reg};
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // ----------------------------------------
  // Station status flags
  // ----------------------------------------
  // Configuration and station type checks
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cfg_err_reg <= 1'b0;
      type_err_reg <= 1'b0;
    end else if (CFG_CHECK) begin
      cfg_err_reg <= !CFG_MATCH;
      type_err_reg <= !TYPE_MATCH;
    end
  end

  // Unsupported function request, set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      unsup_reg <= 1'b0;
    end else if (UNSUP_REQ) begin
      unsup_reg <= 1'b1;
    end else if (wr_clear && WDATA[CLR_UNSUP]) begin
      unsup_reg <= 1'b0;
    end
  end

  // External diagnostics group flag
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ext_diag_reg <= 1'b0;
    end else if (DIAG_ALARM) begin
      ext_diag_reg <= 1'b1;
    end else if (!EXT_DIAG_ACTIVE) begin
      ext_diag_reg <= 1'b0;
    end
  end

  // Parameter-assigning master address
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      prm_valid_reg <= 1'b0;
      prm_master_reg <= 8'h00;
    end else if (PRM_STROBE) begin
      prm_valid_reg <= 1'b1;
      prm_master_reg <= PRM_MASTER;
    end
  end

  // Status bytes; bits 0 and 5 of byte one belong to the master
  always_comb begin
    stat1 = 8'h00;
    stat1[S1_NORESP] = 1'b0;
    stat1[S1_NOTRDY] = !ready_reg;
    stat1[S1_CFGERR] = cfg_err_reg;
    stat1[S1_EXTDIAG] = ext_diag_reg;
    stat1[S1_UNSUP] = unsup_reg;
    stat1[S1_BADRESP] = 1'b0;
    stat1[S1_TYPEERR] = type_err_reg;
    stat1[S1_OTHERPRM] = prm_valid_reg && (prm_master_reg != CUR_MASTER);
    stat2 = 8'h00;
    stat2[S2_ALWAYS1] = 1'b1;
    stat3 = 8'h00;
    stat3[S3_OVFL] = ovfl_reg;
  end

  // ----------------------------------------
  // Interrupt blocks
  // ----------------------------------------
  // Pending diagnostics alarm slot; overflow when full
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      diag_wait_reg <= 1'b0;
      diag_wait_code_reg <= 8'h00;
      ovfl_reg <= 1'b0;
    end else begin
      if (DIAG_ALARM && irq_mode_reg) begin
        if (diag_wait_reg && !issue_blk) begin
          ovfl_reg <= 1'b1;
        end else begin
          diag_wait_reg <= 1'b1;
          diag_wait_code_reg <= DIAG_CODE;
        end
      end else if (issue_blk && diag_wait_reg) begin
        diag_wait_reg <= 1'b0;
      end
      if (wr_clear && WDATA[CLR_OVFL] && !(DIAG_ALARM && diag_wait_reg && !issue_blk)) begin
        ovfl_reg <= 1'b0;
      end
    end
  end

  // Hardware interrupt slot; excess ones are dropped
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hw_wait_reg <= 1'b0;
      hw_wait_code_reg <= 8'h00;
      hw_lost_reg <= 1'b0;
    end else begin
      if (HW_IRQ && irq_mode_reg) begin
        if (hw_wait_reg && !(issue_blk && !diag_wait_reg)) begin
          hw_lost_reg <= 1'b1;
        end else begin
          hw_wait_reg <= 1'b1;
          hw_wait_code_reg <= HW_CODE;
        end
      end else if (issue_blk && !diag_wait_reg) begin
        hw_wait_reg <= 1'b0;
      end
      if (wr_clear && WDATA[CLR_HWLOST] && !(HW_IRQ && hw_wait_reg)) begin
        hw_lost_reg <= 1'b0;
      end
    end
  end

  // New block only when the frame holds none and no read is in flight
  assign issue_blk = !blk_valid_reg && (diag_wait_reg || hw_wait_reg)
                     && (state_reg == SDF_IDLE);

  // Block in the frame stays until the master acknowledges it
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      blk_valid_reg <= 1'b0;
      blk_kind_reg <= 8'h00;
      blk_code_reg <= 8'h00;
      blk_seq_reg <= 8'h00;
    end else if (issue_blk) begin
      blk_valid_reg <= 1'b1;
      blk_kind_reg <= diag_wait_reg ? BLK_KIND_DIAG : BLK_KIND_HW;
      blk_code_reg <= diag_wait_reg ? diag_wait_code_reg : hw_wait_code_reg;
      blk_seq_reg <= blk_seq_reg + 8'h01;
    end else if (BLK_ACK && blk_valid_reg) begin
      blk_valid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Error lamp
  // ----------------------------------------
  // Blink divider gives one-cycle enable pulses
  always_ff @(posedge CLK_SYS) begin
    if (RST || !led_active_reg) begin
      blink_cnt_reg <= 32'h0000_0000;
    end else if (blink_tick) begin
      blink_cnt_reg <= 32'h0000_0000;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end
  assign blink_tick = (blink_cnt_reg == 32'(BLINK_HALF - 1));

  // Lamp flashes from an alarm until diagnostics are gone
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      led_active_reg <= 1'b0;
      led_reg <= 1'b0;
    end else if (DIAG_ALARM) begin
      if (!led_active_reg) begin
        led_reg <= 1'b1;
      end
      led_active_reg <= 1'b1;
    end else if (!ext_diag_reg) begin
      led_active_reg <= 1'b0;
      led_reg <= 1'b0;
    end else if (blink_tick) begin
      led_reg <= !led_reg;
    end
  end
  assign ERR_LED = led_reg;

  // ----------------------------------------
  // Frame serializer
  // ----------------------------------------
  // Current length: header, extension bytes, optional block
  assign frame_len = 8'(FRAME_MIN) + ext_len_reg
                     + (blk_valid_reg ? 8'(BLK_LEN) : 8'h00);

  // Byte selected by index
  function automatic logic [7:0] frame_byte(input logic [7:0] i);
    logic [7:0] e;
    e = i - 8'(FRAME_MIN);
    if (i == POS_STAT1) frame_byte = stat1;
    else if (i == POS_STAT2) frame_byte = stat2;
    else if (i == POS_STAT3) frame_byte = stat3;
    else if (i == POS_MADDR) frame_byte = prm_master_reg;
    else if (i == POS_IDHI) frame_byte = ident_reg[15:8];
    else if (i == POS_IDLO) frame_byte = ident_reg[7:0];
    else if (e < ext_len_reg) frame_byte = ext_mem[e];
    else begin
      unique case (2'(e - ext_len_reg))
        2'd0: frame_byte = 8'(BLK_LEN);
        2'd1: frame_byte = blk_kind_reg;
        2'd2: frame_byte = blk_code_reg;
        default: frame_byte = blk_seq_reg;
      endcase
    end
  endfunction : frame_byte

  assign accept = (state_reg == SDF_SEND) && FRM_READY;
  assign next_idx = (state_reg == SDF_IDLE) ? 8'h00 : idx_reg + 8'h01;
  // Byte mux follows every frame field, not only the index
  always_comb begin
    byte_sel = frame_byte(next_idx);
  end

  // Ascending bytes, exactly the latched length
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg <= SDF_IDLE;
      idx_reg <= 8'h00;
      len_reg <= 8'h00;
      data_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        SDF_IDLE: begin
          if (FRM_REQ && !issue_blk) begin
            state_reg <= SDF_SEND;
            idx_reg <= 8'h00;
            len_reg <= frame_len;
            data_reg <= byte_sel;
          end
        end
        SDF_SEND: begin
          if (accept) begin
            if (idx_reg == len_reg - 8'h01) begin
              state_reg <= SDF_IDLE;
            end else begin
              idx_reg <= next_idx;
              data_reg <= byte_sel;
            end
          end
        end
      endcase
    end
  end

  assign FRM_VALID = (state_reg == SDF_SEND);
  assign FRM_DATA = data_reg;
  assign FRM_LAST = (state_reg == SDF_SEND) && (idx_reg == len_reg - 8'h01);
endmodule : sdf_diag_frame

// [inc/sdf_pkg.sv]
// Constants shared by the slave diagnostics frame block.
// Assumes a 200 MHz system clock and byte-wide frame bytes.
package sdf_pkg;
  // ----------------------------------------
  // Register bus and register offsets
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_EXTLEN = 8'h0C;
  localparam logic [7:0] OFS_EXTDATA = 8'h10;
  localparam logic [7:0] OFS_IDENT = 8'h14;
  // Control bits
  localparam int CTRL_IRQ_MODE = 0;
  localparam int CTRL_READY = 1;
  // Clear bits, write one to clear
  localparam int CLR_UNSUP = 0;
  localparam int CLR_OVFL = 1;
  localparam int CLR_HWLOST = 2;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_MIN = 6;
  localparam int FRAME_MAX = 244;
  localparam int BLK_LEN = 4;
  localparam int EXT_MAX = FRAME_MAX - FRAME_MIN - BLK_LEN;
  localparam logic [7:0] POS_STAT1 = 8'h00;
  localparam logic [7:0] POS_STAT2 = 8'h01;
  localparam logic [7:0] POS_STAT3 = 8'h02;
  localparam logic [7:0] POS_MADDR = 8'h03;
  localparam logic [7:0] POS_IDHI = 8'h04;
  localparam logic [7:0] POS_IDLO = 8'h05;
  // Station status 1, 2 and 3 bit positions
  localparam int S1_NORESP = 0;
  localparam int S1_NOTRDY = 1;
  localparam int S1_CFGERR = 2;
  localparam int S1_EXTDIAG = 3;
  localparam int S1_UNSUP = 4;
  localparam int S1_BADRESP = 5;
  localparam int S1_TYPEERR = 6;
  localparam int S1_OTHERPRM = 7;
  localparam int S2_ALWAYS1 = 2;
  localparam int S3_OVFL = 7;
  // Interrupt block kinds
  localparam logic [7:0] BLK_KIND_DIAG = 8'h01;
  localparam logic [7:0] BLK_KIND_HW = 8'h02;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint CLK_HZ = 200_000_000;
  localparam longint BLINK_HALF_MS = 250;
  localparam longint BLINK_HALF_CYC = BLINK_HALF_MS * CLK_HZ / 1000;
  typedef enum logic [1:0] {
    SDF_IDLE = 2'b01,
    SDF_SEND = 2'b10
  } sdf_state_t;
endpackage : sdf_pkg

// [bench/sdf_diag_frame_properties.sv]
// Port checker for the diagnostics frame block.
// Assumes it is bound to sdf_diag_frame on one clock.
`timescale 1ns/1ps
module sdf_props (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic RD,
  input wire logic [sdf_pkg::DATA_W-1:0] RDATA,
  input wire logic FRM_READY,
  input wire logic FRM_VALID,
  input wire logic [7:0] FRM_DATA,
  input wire logic FRM_LAST
);
  import sdf_pkg::*;
  logic [7:0] cnt_reg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Counts bytes taken in the current frame
  always_ff @(posedge CLK_SYS) begin
    if (RST || (FRM_VALID && FRM_READY && FRM_LAST)) cnt_reg <= 8'h00;
    else if (FRM_VALID && FRM_READY) cnt_reg <= cnt_reg + 8'h01;
  end
  // ---
  // Assertions
  // ---
  a_rdata_quiet: assert property (!$past(RD) |-> RDATA == '0)
    else $error("read data not zero outside read");
  a_byte_held: assert property (FRM_VALID && !FRM_READY |=> FRM_VALID && $stable(FRM_DATA))
    else $error("frame byte dropped while stalled");
  a_last_ends: assert property (FRM_VALID && FRM_READY && FRM_LAST |=> !FRM_VALID)
    else $error("frame continues past last byte");
  a_last_valid: assert property (FRM_LAST |-> FRM_VALID)
    else $error("last flag without valid");
  a_stat1_first: assert property ($rose(FRM_VALID) |-> cnt_reg == 8'h00
    && !FRM_DATA[S1_NORESP] && !FRM_DATA[S1_BADRESP])
    else $error("first byte is not station status one");
  a_frame_len: assert property (FRM_VALID && FRM_LAST |-> cnt_reg >= 8'h05 && cnt_reg <= 8'hf3)
    else $error("frame length out of range");
  a_stat2_one: assert property (FRM_VALID && cnt_reg == 8'h01 |-> FRM_DATA[S2_ALWAYS1])
    else $error("station status two fixed bit low");
  a_stat3_low: assert property (FRM_VALID && cnt_reg == 8'h02 |-> FRM_DATA[6:0] == 7'h00)
    else $error("station status three low bits set");
  c_frame_end: cover property (FRM_VALID && FRM_READY && FRM_LAST);
  c_stall: cover property (FRM_VALID && !FRM_READY);
  c_read: cover property (RD);
endmodule : sdf_props
bind sdf_diag_frame sdf_props sdf_props_i (.CLK_SYS(CLK_SYS), .RST(RST), .RD(RD),
  .RDATA(RDATA), .FRM_READY(FRM_READY), .FRM_VALID(FRM_VALID), .FRM_DATA(FRM_DATA),
  .FRM_LAST(FRM_LAST));

// [bench/sdf_master_model.sv]
// Master controller model: asks for diagnostics frames and collects them.
// Assumes it shares the block clock and is commanded by the bench.
`timescale 1ns/1ps
module sdf_master_model (
  input wire logic clk,
  input wire logic frm_valid,
  input wire logic [7:0] frm_data,
  input wire logic frm_last,
  output logic frm_req = 1'b0,
  output logic frm_ready = 1'b0,
  output logic blk_ack = 1'b0
);
  logic no_answer = 1'b0; // Own flag for a silent slave
  logic bad_resp = 1'b0; // Own flag for an unreadable frame
  // Acknowledge the pending block, then let the next one settle
  task automatic ack();
    @(posedge clk);
    blk_ack <= 1'b1;
    @(posedge clk);
    blk_ack <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : ack
  // Request a frame, retry if refused, take bytes with random stalls
  task automatic fetch(input int stall, output logic [7:0] q[$]);
    logic v;
    q = {};
    v = 1'b0;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      frm_req <= (n % 8 == 0) && !v && (q.size() == 0);
      frm_ready <= ($urandom_range(99) >= stall);
      @(negedge clk);
      v = frm_valid;
      if (v && frm_ready) q.push_back(frm_data);
      if (v && frm_ready && frm_last) break;
    end
    @(posedge clk);
    frm_ready <= 1'b0;
    no_answer = (q.size() == 0);
    bad_resp = (q.size() > 0) && ((q.size() < sdf_pkg::FRAME_MIN)
               || (q.size() > sdf_pkg::FRAME_MAX));
  endtask : fetch
endmodule : sdf_master_model

// [bench/sdf_diag_frame_tb_top.sv]
// Bench for the diagnostics frame block: registers, events and frames.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module sdf_diag_frame_tb_top;
  import sdf_pkg::*;
  typedef logic [7:0] sdf_bytes_t[$];
  logic clk_sys, rst = 1'b1, wr = 1'b0, rd = 1'b0, diag_alarm = 1'b0, hw_irq = 1'b0;
  logic cfg_check = 1'b0, cfg_match = 1'b1, type_match = 1'b1, unsup_req = 1'b0;
  logic prm_strobe = 1'b0, ext_diag_active = 1'b0;
  logic blk_ack, frm_req, frm_ready, frm_valid, frm_last, err_led;
  logic [7:0] addr = 8'h00, diag_code = 8'h00, hw_code = 8'h00;
  logic [7:0] prm_master = 8'h00, cur_master = 8'h00, frm_data;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [7:0] stat1_e = 8'h02, stat3_e = 8'h00, prm_e, bkind, bcode, bseq = 8'h00;
  logic [15:0] ident_e;
  logic bvalid = 1'b0;
  int ext_n = 0, miscompares = 0, samples_checked = 0;
  sdf_bytes_t ext_e;
  sdf_diag_frame #(.BLINK_HALF(4)) sdf_diag_frame_i (.CLK_SYS(clk_sys), .RST(rst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DIAG_ALARM(diag_alarm),
    .DIAG_CODE(diag_code), .EXT_DIAG_ACTIVE(ext_diag_active), .HW_IRQ(hw_irq),
    .HW_CODE(hw_code), .BLK_ACK(blk_ack), .CFG_CHECK(cfg_check), .CFG_MATCH(cfg_match),
    .TYPE_MATCH(type_match), .UNSUP_REQ(unsup_req), .PRM_STROBE(prm_strobe),
    .PRM_MASTER(prm_master), .CUR_MASTER(cur_master), .FRM_REQ(frm_req),
    .FRM_READY(frm_ready), .FRM_VALID(frm_valid), .FRM_DATA(frm_data),
    .FRM_LAST(frm_last), .ERR_LED(err_led));
  sdf_master_model sdf_master_model_i (.clk(clk_sys), .frm_valid(frm_valid),
    .frm_data(frm_data), .frm_last(frm_last), .frm_req(frm_req), .frm_ready(frm_ready),
    .blk_ack(blk_ack));
  // ---
  // Expectations and checks
  // ---
  function automatic sdf_bytes_t exp_frame();
    sdf_bytes_t e;
    e = {stat1_e, 8'h04, stat3_e, prm_e, ident_e[15:8], ident_e[7:0]};
    e = {e, ext_e};
    if (bvalid) e = {e, 8'(BLK_LEN), bkind, bcode, bseq};
    return e;
  endfunction : exp_frame
  function automatic logic [31:0] exp_status();
    return {8'h00, 8'(6 + ext_n + (bvalid ? 4 : 0)), stat3_e, stat1_e};
  endfunction : exp_status
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // Register access on the plain strobe bus
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check("register", rdata & m, e);
    @(posedge clk_sys);
  endtask : rd_chk
  // One-cycle event pulse, then time for the block to react
  task automatic ev(input int k);
    @(posedge clk_sys);
    case (k)
      0: diag_alarm <= 1'b1;
      1: hw_irq <= 1'b1;
      2: cfg_check <= 1'b1;
      3: unsup_req <= 1'b1;
      default: prm_strobe <= 1'b1;
    endcase
    @(posedge clk_sys);
    {diag_alarm, hw_irq, cfg_check, unsup_req, prm_strobe} <= 5'h00;
    repeat (3) @(posedge clk_sys);
  endtask : ev
  task automatic frame_chk(input int stall);
    sdf_bytes_t q, e;
    sdf_master_model_i.fetch(stall, q);
    e = exp_frame();
    check("master flags", {30'h0, sdf_master_model_i.no_answer, sdf_master_model_i.bad_resp}, 32'h0000_0000);
    check("frame length", 32'(q.size()), 32'(e.size()));
    foreach (e[i]) if (i < q.size()) check("frame byte", 32'(q[i]), 32'(e[i]));
  endtask : frame_chk
  // ---
  // Clock, watchdog and main sequence
  // ---
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end
  initial begin
    logic [7:0] codes[3];
    logic [7:0] hcode;
    int tog;
    logic led_q;
    void'($urandom(38));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(OFS_STATUS, 32'h00ff_ffff, exp_status());
    rd_chk(8'hfc, 32'hffff_ffff, 32'h0000_0000);
    wr_reg(OFS_CTRL, 32'h0000_0003);
    stat1_e[S1_NOTRDY] = 1'b0;
    rd_chk(OFS_STATUS, 32'h00ff_ffff, exp_status());
    ident_e = 16'($urandom);
    wr_reg(OFS_IDENT, {16'h0000, ident_e});
    prm_e = 8'($urandom_range(1, 125));
    prm_master <= prm_e;
    ev(4);
    stat1_e[S1_OTHERPRM] = 1'b1;
    frame_chk(30);
    cur_master <= prm_e;
    stat1_e[S1_OTHERPRM] = 1'b0;
    frame_chk(0);
    cfg_match <= 1'b0;
    type_match <= 1'b0;
    ev(2);
    ev(3);
    stat1_e = stat1_e | 8'h54;
    frame_chk(10);
    cfg_match <= 1'b1;
    type_match <= 1'b1;
    ev(2);
    wr_reg(OFS_CLEAR, 32'h0000_0001);
    stat1_e = stat1_e & 8'hab;
    rd_chk(OFS_STATUS, 32'h00ff_ffff, exp_status());
    ext_n = $urandom_range(1, 8);
    wr_reg(OFS_EXTLEN, 32'(ext_n));
    for (int i = 0; i < ext_n; i++) begin
      ext_e.push_back(8'($urandom));
      wr_reg(OFS_EXTDATA, {16'h0000, 8'(i), ext_e[i]});
    end
    frame_chk(50);
    wr_reg(OFS_EXTLEN, 32'h0000_00ff);
    ext_n = 234;
    rd_chk(OFS_STATUS, 32'h00ff_ffff, exp_status());
    ext_n = ext_e.size();
    wr_reg(OFS_EXTLEN, 32'(ext_n));
    // Alarm outside interrupt mode leaves no block
    ext_diag_active <= 1'b1;
    stat1_e[S1_EXTDIAG] = 1'b1;
    wr_reg(OFS_CTRL, 32'h0000_0002);
    ev(0);
    frame_chk(0);
    wr_reg(OFS_CTRL, 32'h0000_0003);
    for (int k = 0; k < 3; k++) begin
      codes[k] = 8'($urandom);
      diag_code <= codes[k];
      ev(0);
    end
    hcode = 8'($urandom);
    hw_code <= hcode;
    ev(1);
    ev(1);
    bvalid = 1'b1;
    bseq = bseq + 8'h01;
    bkind = BLK_KIND_DIAG;
    bcode = codes[0];
    stat3_e = 8'h80;
    rd_chk(OFS_STATUS, 32'h08ff_ffff, exp_status() | 32'h0800_0000);
    frame_chk(20);
    tog = 0;
    led_q = err_led;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      if (err_led !== led_q) tog++;
      led_q = err_led;
    end
    check("lamp toggles", 32'(tog >= 7 && tog <= 11), 32'h0000_0001);
    sdf_master_model_i.ack();
    bcode = codes[1];
    bseq = bseq + 8'h01;
    frame_chk(0);
    sdf_master_model_i.ack();
    bkind = BLK_KIND_HW;
    bcode = hcode;
    bseq = bseq + 8'h01;
    frame_chk(40);
    sdf_master_model_i.ack();
    bvalid = 1'b0;
    wr_reg(OFS_CLEAR, 32'h0000_0006);
    stat3_e = 8'h00;
    rd_chk(OFS_STATUS, 32'h08ff_ffff, exp_status());
    ext_diag_active <= 1'b0;
    stat1_e[S1_EXTDIAG] = 1'b0;
    repeat (12) @(posedge clk_sys);
    rd_chk(OFS_STATUS, 32'h00ff_ffff, exp_status());
    check("lamp", {31'h0, err_led}, 32'h0000_0000);
    for (int k = 0; k < 4; k++) frame_chk(25 * k);
    finish_test();
  end
endmodule : sdf_diag_frame_tb_top
